// file: shared/brl_pkg.sv
// shared constants, carriers and helpers of the bootstrap record loader
package brl_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_DEF = 9600;
  localparam int BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [3:0] BIT_RST = 4'h0;
  localparam logic [3:0] RX_LAST_BIT = 4'h7;
  localparam logic [3:0] TX_LAST_BIT = 4'h9;
  localparam logic [9:0] TX_SH_RST = 10'h3FF;

  // ==========================================================
  // record format
  localparam logic [7:0] CHAR_FLOOR = 8'h30;
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [31:0] IBUF_ADDR = 32'hFFFFFFC0;
  localparam int IBUF_BYTES_DEF = 16;
  localparam logic [3:0] ADDR_LAST = 4'h7;
  localparam logic [3:0] COUNT_LAST = 4'h1;
  localparam logic [3:0] DIGIT_RST = 4'h0;
  localparam logic [31:0] ADDR_RST = 32'h00000000;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ==========================================================
  // types
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } brl_char_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [7:0] data;
  } brl_wr_s;

  typedef enum logic [2:0] {BRL_ADDR, BRL_COUNT, BRL_DATA, BRL_SKIP, BRL_EXEC} brl_state_e;
  typedef enum logic [1:0] {BRL_RX_IDLE, BRL_RX_START, BRL_RX_DATA, BRL_RX_STOP} brl_rx_e;
  typedef enum logic {BRL_TX_IDLE, BRL_TX_RUN} brl_tx_e;

  // uppercase hex digit decode: bit 4 set when the code is a digit
  function automatic logic [4:0] brl_hex(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      r = {1'b1, c[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      r = {1'b1, 4'(c[3:0] + 4'h9)};
    end
    return r;
  endfunction
endpackage

// file: src/brl_uart.sv
// serial receive and echo transmit for the bootstrap loader
module brl_uart #(
  parameter logic [15:0] BIT_CYCLES = 16'(brl_pkg::BIT_CYC_DEF)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic boot_mode,
  input wire logic rxd,
  output logic txd_q,
  output brl_pkg::brl_char_s char_q
);
  import brl_pkg::*;

  // ==========================================================
  // receive
  logic rx1_q, rx2_q, rx3_q, lvl_q, lvl_d;
  brl_rx_e rx_st_q, rx_st_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  brl_char_s char_d;

  // level moves only once the second and third stages agree
  always_comb begin
    lvl_d = (rx2_q == rx3_q) ? rx3_q : lvl_q;
    rx_st_d = rx_st_q;
    rx_cnt_d = (rx_cnt_q == CNT_RST) ? CNT_RST : 16'(rx_cnt_q - 16'h0001);
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    char_d = '0;
    case (rx_st_q)
      BRL_RX_IDLE: begin
        if (!lvl_q) begin
          rx_st_d = BRL_RX_START;
          rx_cnt_d = BIT_CYCLES >> 1;
        end
      end
      BRL_RX_START: begin
        if (rx_cnt_q == CNT_RST) begin
          rx_st_d = lvl_q ? BRL_RX_IDLE : BRL_RX_DATA; // glitch guard
          rx_cnt_d = BIT_CYCLES;
          rx_bit_d = BIT_RST;
        end
      end
      BRL_RX_DATA: begin
        if (rx_cnt_q == CNT_RST) begin
          rx_sh_d = {lvl_q, rx_sh_q[7:1]};
          rx_cnt_d = BIT_CYCLES;
          rx_bit_d = 4'(rx_bit_q + 4'h1);
          if (rx_bit_q == RX_LAST_BIT) begin
            rx_st_d = BRL_RX_STOP;
          end
        end
      end
      default: begin
        if (rx_cnt_q == CNT_RST) begin
          rx_st_d = BRL_RX_IDLE;
          char_d.valid = lvl_q & boot_mode; // framing errors dropped
          char_d.code = rx_sh_q;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx1_q <= 1'b1;
      rx2_q <= 1'b1;
      rx3_q <= 1'b1;
      lvl_q <= 1'b1;
      rx_st_q <= BRL_RX_IDLE;
      rx_cnt_q <= CNT_RST;
      rx_bit_q <= BIT_RST;
      rx_sh_q <= CHAR_RST;
      char_q <= '0;
    end else begin
      rx1_q <= rxd;
      rx2_q <= rx1_q;
      rx3_q <= rx2_q;
      lvl_q <= lvl_d;
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      char_q <= char_d;
    end
  end

  // ==========================================================
  // echo transmit
  brl_tx_e tx_st_q, tx_st_d;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic pend_q, pend_d, txd_d;
  logic [7:0] pend_code_q, pend_code_d;

  // one pending slot: a char arriving while one waits replaces it
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = (tx_cnt_q == CNT_RST) ? CNT_RST : 16'(tx_cnt_q - 16'h0001);
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    pend_d = pend_q;
    pend_code_d = pend_code_q;
    txd_d = txd_q;
    case (tx_st_q)
      BRL_TX_IDLE: begin
        txd_d = 1'b1;
        if (pend_q) begin
          tx_st_d = BRL_TX_RUN;
          tx_sh_d = {1'b1, pend_code_q, 1'b0};
          tx_cnt_d = BIT_CYCLES;
          tx_bit_d = BIT_RST;
          pend_d = 1'b0;
          txd_d = 1'b0;
        end
      end
      default: begin
        if (tx_cnt_q == CNT_RST) begin
          tx_sh_d = {1'b1, tx_sh_q[9:1]};
          tx_cnt_d = BIT_CYCLES;
          tx_bit_d = 4'(tx_bit_q + 4'h1);
          txd_d = tx_sh_q[1];
          if (tx_bit_q == TX_LAST_BIT) begin
            tx_st_d = BRL_TX_IDLE;
            txd_d = 1'b1;
          end
        end
      end
    endcase
    if (char_q.valid) begin
      pend_d = 1'b1;
      pend_code_d = char_q.code;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_st_q <= BRL_TX_IDLE;
      tx_cnt_q <= CNT_RST;
      tx_bit_q <= BIT_RST;
      tx_sh_q <= TX_SH_RST;
      pend_q <= 1'b0;
      pend_code_q <= CHAR_RST;
      txd_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      pend_q <= pend_d;
      pend_code_q <= pend_code_d;
      txd_q <= txd_d;
    end
  end

  // ==========================================================
  // checks
  a_echo_queued: assert property (@(posedge sys_clk) disable iff (!nrst)
    char_q.valid |=> pend_q && pend_code_q == $past(char_q.code))
    else $error("received char not queued for echo");
  a_line_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    (tx_st_q == BRL_TX_IDLE && !pend_q) |=> txd_q)
    else $error("transmit line not idle high");
endmodule // brl_uart

// file: src/brl_loader.sv
// bootstrap record loader: record assembly, memory writes, instruction buffer
module brl_loader #(
  parameter logic [15:0] BIT_CYCLES = 16'(brl_pkg::BIT_CYC_DEF),
  parameter int IBUF_BYTES = brl_pkg::IBUF_BYTES_DEF
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic boot_mode,
  input wire logic rxd,
  output logic txd_q,
  output brl_pkg::brl_wr_s mem_wr_q,
  output logic exec_req_q,
  output logic exec_ibuf_q,
  output logic [31:0] exec_addr_q,
  input wire logic exec_done,
  input wire logic [$clog2(IBUF_BYTES)-1:0] ibuf_rd_idx,
  output logic [7:0] ibuf_rd_q
);
  import brl_pkg::*;

  localparam int IW = $clog2(IBUF_BYTES);

  // ==========================================================
  // serial side
  brl_char_s ch;

  brl_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .boot_mode(boot_mode),
    .rxd(rxd),
    .txd_q(txd_q),
    .char_q(ch)
  );

  // ==========================================================
  // record assembly
  brl_state_e st_q, st_d;
  logic [3:0] dig_q, dig_d, nib_q, nib_d;
  logic half_q, half_d;
  logic [31:0] addr_q, addr_d;
  logic [7:0] cnt_q, cnt_d;
  brl_wr_s wr_d;
  logic exec_req_d, exec_ibuf_d;
  logic [31:0] exec_addr_d;
  logic ibuf_we;
  logic [7:0] ibuf_q [IBUF_BYTES];
  logic [7:0] ibuf_rd_d;
  logic [4:0] hex;
  logic [7:0] cnt_new;
  logic in_ibuf;

  assign hex = brl_hex(ch.code);
  assign cnt_new = {cnt_q[3:0], hex[3:0]};
  // buffer is aligned, so the upper address bits alone select it
  assign in_ibuf = (addr_q[31:IW] == IBUF_ADDR[31:IW]);

  // next state of the record interpreter
  always_comb begin
    st_d = st_q;
    dig_d = dig_q;
    nib_d = nib_q;
    half_d = half_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    wr_d = '0;
    ibuf_we = 1'b0;
    exec_req_d = exec_req_q;
    exec_ibuf_d = exec_ibuf_q;
    exec_addr_d = exec_addr_q;
    if (!boot_mode) begin
      st_d = BRL_ADDR;
      dig_d = DIGIT_RST;
      half_d = 1'b0;
      exec_req_d = 1'b0;
    end else if (st_q == BRL_EXEC) begin
      // chars are still echoed but ignored while code runs
      if (exec_done) begin
        exec_req_d = 1'b0;
        st_d = BRL_ADDR;
        dig_d = DIGIT_RST;
        half_d = 1'b0;
      end
    end else if (ch.valid) begin
      if (ch.code < CHAR_FLOOR) begin
        st_d = BRL_ADDR;
        dig_d = DIGIT_RST;
        half_d = 1'b0;
      end else if (!hex[4]) begin
        st_d = BRL_SKIP; // comment text, discarded
      end else begin
        case (st_q)
          BRL_ADDR: begin
            addr_d = {addr_q[27:0], hex[3:0]};
            dig_d = 4'(dig_q + 4'h1);
            if (dig_q == ADDR_LAST) begin
              st_d = BRL_COUNT;
              dig_d = DIGIT_RST;
            end
          end
          BRL_COUNT: begin
            cnt_d = cnt_new;
            dig_d = 4'(dig_q + 4'h1);
            if (dig_q == COUNT_LAST) begin
              dig_d = DIGIT_RST;
              if (cnt_new == COUNT_RST) begin
                st_d = BRL_EXEC;
                exec_req_d = 1'b1;
                exec_ibuf_d = (addr_q == IBUF_ADDR);
                exec_addr_d = addr_q;
              end else begin
                st_d = BRL_DATA;
              end
            end
          end
          BRL_DATA: begin
            if (!half_q) begin
              nib_d = hex[3:0];
              half_d = 1'b1;
            end else begin
              half_d = 1'b0;
              if (in_ibuf) begin
                ibuf_we = 1'b1;
              end else begin
                wr_d.valid = 1'b1;
                wr_d.addr = addr_q;
                wr_d.data = {nib_q, hex[3:0]};
              end
              addr_d = 32'(addr_q + 32'h00000001);
              cnt_d = 8'(cnt_q - COUNT_ONE);
              if (cnt_q == COUNT_ONE) begin
                st_d = BRL_SKIP;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
    ibuf_rd_d = ibuf_q[ibuf_rd_idx];
  end

  // register the interpreter state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q <= BRL_ADDR;
      dig_q <= DIGIT_RST;
      nib_q <= DIGIT_RST;
      half_q <= 1'b0;
      addr_q <= ADDR_RST;
      cnt_q <= COUNT_RST;
      mem_wr_q <= '0;
      exec_req_q <= 1'b0;
      exec_ibuf_q <= 1'b0;
      exec_addr_q <= ADDR_RST;
      ibuf_rd_q <= CHAR_RST;
    end else begin
      st_q <= st_d;
      dig_q <= dig_d;
      nib_q <= nib_d;
      half_q <= half_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      mem_wr_q <= wr_d;
      exec_req_q <= exec_req_d;
      exec_ibuf_q <= exec_ibuf_d;
      exec_addr_q <= exec_addr_d;
      ibuf_rd_q <= ibuf_rd_d;
    end
  end

  // buffer storage has no reset; the host loads it before running it
  always_ff @(posedge sys_clk) begin
    if (ibuf_we) begin
      ibuf_q[addr_q[IW-1:0]] <= {nib_q, hex[3:0]};
    end
  end

  // ==========================================================
  // checks
  a_low_char_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
    (boot_mode && ch.valid && ch.code < CHAR_FLOOR && st_q != BRL_EXEC)
      |=> st_q == BRL_ADDR && dig_q == DIGIT_RST && !half_q)
    else $error("low char did not restart the record");
  a_low_char_ignored: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ch.valid && ch.code < CHAR_FLOOR) |=> !mem_wr_q.valid && $stable(addr_q))
    else $error("low char took part in assembly");
  a_addr_shift: assert property (@(posedge sys_clk) disable iff (!nrst)
    (boot_mode && ch.valid && hex[4] && st_q == BRL_ADDR)
      |=> addr_q == {$past(addr_q[27:0]), $past(hex[3:0])})
    else $error("address digit not shifted in");
  a_wr_advance: assert property (@(posedge sys_clk) disable iff (!nrst)
    mem_wr_q.valid |-> addr_q == 32'(mem_wr_q.addr + 32'h00000001))
    else $error("write address did not advance");
  a_ibuf_no_mem: assert property (@(posedge sys_clk) disable iff (!nrst)
    mem_wr_q.valid |-> mem_wr_q.addr[31:IW] != IBUF_ADDR[31:IW])
    else $error("buffer byte leaked to memory");
  a_exec_ibuf: assert property (@(posedge sys_clk) disable iff (!nrst)
    (boot_mode && ch.valid && hex[4] && st_q == BRL_COUNT && dig_q == COUNT_LAST
      && cnt_new == COUNT_RST && addr_q == IBUF_ADDR)
      |=> exec_req_q && exec_ibuf_q && exec_addr_q == IBUF_ADDR)
    else $error("buffer execution not requested");
  a_exec_no_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    (exec_req_q && !exec_done && boot_mode) |=> exec_req_q && !mem_wr_q.valid)
    else $error("execution dropped or wrote data");
  a_exec_release: assert property (@(posedge sys_clk) disable iff (!nrst)
    (boot_mode && exec_req_q && exec_done) |=> !exec_req_q ##1 (st_q != BRL_EXEC))
    else $error("loader did not resume after execution");

  c_mem_write: cover property (@(posedge sys_clk) disable iff (!nrst) mem_wr_q.valid);
  c_ibuf_write: cover property (@(posedge sys_clk) disable iff (!nrst) ibuf_we);
  c_exec_ibuf: cover property (@(posedge sys_clk) disable iff (!nrst) exec_req_q && exec_ibuf_q);
  c_restart: cover property (@(posedge sys_clk) disable iff (!nrst)
    ch.valid && ch.code < CHAR_FLOOR && st_q == BRL_DATA);
endmodule // brl_loader

// file: verif/brl_host.sv
// host terminal model: sends characters on rxd and collects the echo from txd
module brl_host #(
  parameter int BIT = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sent_q[$];
  logic [7:0] echo_q[$];

  // ==========================================================
  // transmit side
  // line idles high, as the pull-up on the receive pin leaves it
  initial begin
    rxd = 1'b1;
  end

  // one 8N1 frame, lsb first, changed on the falling edge;
  // each bit stands BIT+1 cycles, the loader's own bit period, so its sampling never drifts
  task automatic send_char(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b1, c, 1'b0};
    sent_q.push_back(c);
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      rxd = fr[i];
      repeat (BIT) @(negedge sys_clk);
    end
    // idle gap so the echo ends before the next frame has been fully received
    repeat (4 * BIT) @(negedge sys_clk);
  endtask

  // ==========================================================
  // echo receiver
  // samples mid-bit on the falling edge, away from the edge that moves txd; bits stand BIT+1 cycles
  always begin : echo_rx
    logic [7:0] c;
    @(negedge txd);
    if (nrst === 1'b1) begin
      repeat ((BIT + 1) / 2) @(negedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT + 1) @(negedge sys_clk);
        c[i] = txd;
      end
      echo_q.push_back(c);
    end
  end
endmodule // brl_host

// file: verif/bootstrap_record_loader_bench.sv
// self-checking bench of the bootstrap record loader
module bootstrap_record_loader_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import brl_pkg::*;
  localparam int BIT = 8;
  localparam int LIMIT = 60000;
  logic sys_clk, nrst, boot_mode, rxd, txd_q, exec_req_q, exec_ibuf_q, exec_done;
  brl_wr_s mem_wr_q;
  logic [31:0] exec_addr_q;
  logic [3:0] ibuf_rd_idx;
  logic [7:0] ibuf_rd_q;
  int failures, n_compared, cyc;
  logic [39:0] wr_q[$];
  logic [39:0] exp_q[$];

  // ==========================================================
  // instances
  brl_loader #(.BIT_CYCLES(16'(BIT)), .IBUF_BYTES(16)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .boot_mode(boot_mode), .rxd(rxd), .txd_q(txd_q),
    .mem_wr_q(mem_wr_q), .exec_req_q(exec_req_q), .exec_ibuf_q(exec_ibuf_q),
    .exec_addr_q(exec_addr_q), .exec_done(exec_done), .ibuf_rd_idx(ibuf_rd_idx), .ibuf_rd_q(ibuf_rd_q)
  );
  brl_host #(.BIT(BIT)) host_u (.sys_clk(sys_clk), .nrst(nrst), .txd(txd_q), .rxd(rxd));

  // 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // write collector and hang guard; falling edge, where the write pulse is settled
  always @(negedge sys_clk) begin
    cyc++;
    if (mem_wr_q.valid === 1'b1) begin
      wr_q.push_back({mem_wr_q.addr, mem_wr_q.data});
    end
    if (cyc == LIMIT) begin
      failures++;
      $display("[FAIL] %0t run did not finish in time", $time);
      tally_and_finish();
    end
  end

  // ==========================================================
  // helpers
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction

  // uppercase digits, most significant first
  task automatic send_hex(input logic [31:0] v, input int nd);
    for (int i = nd - 1; i >= 0; i--) host_u.send_char(hex_ch(v[i*4 +: 4]));
  endtask

  // data record; bytes outside the buffer window become expected writes
  task automatic send_rec(input logic [31:0] a, input logic [7:0] b[$]);
    send_hex(a, 8);
    send_hex(32'(b.size()), 2);
    foreach (b[i]) begin
      send_hex(32'(b[i]), 2);
      if (((a + 32'(i)) & 32'hFFFFFFF0) !== IBUF_ADDR) exp_q.push_back({a + 32'(i), b[i]});
    end
    host_u.send_char(8'h0D);
  endtask

  // lets the line drain, then matches writes and echoes
  task automatic check_all();
    repeat (20 * BIT) @(negedge sys_clk);
    cmp(40'(wr_q.size()), 40'(exp_q.size()), "write count");
    while (wr_q.size() > 0 && exp_q.size() > 0) cmp(wr_q.pop_front(), exp_q.pop_front(), "write");
    cmp(40'(host_u.echo_q.size()), 40'(host_u.sent_q.size()), "echo count");
    while (host_u.echo_q.size() > 0 && host_u.sent_q.size() > 0)
      cmp(40'(host_u.echo_q.pop_front()), 40'(host_u.sent_q.pop_front()), "echo");
    wr_q.delete();
    exp_q.delete();
    host_u.echo_q.delete();
    host_u.sent_q.delete();
  endtask

  task automatic run_exec(input logic [31:0] a, input logic ib);
    send_hex(a, 8);
    send_hex(32'h0, 2);
    cmp(40'({exec_req_q, exec_ibuf_q, exec_addr_q}), 40'({1'b1, ib, a}), "exec start");
    host_u.send_char(8'h0D);
  endtask

  // cpu reports the end of execution with a one-cycle pulse after a random run time;
  // the modelled code leaves the loader's working registers alone
  task automatic finish_exec();
    repeat (1 + $urandom_range(5)) @(negedge sys_clk);
    cmp(40'(exec_req_q), 40'h1, "exec held");
    exec_done = 1'b1;
    @(negedge sys_clk);
    exec_done = 1'b0;
    @(negedge sys_clk);
    cmp(40'(exec_req_q), 40'h0, "exec end");
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] b[$];
    logic [31:0] a;
    int idx;
    nrst = 1'b0;
    boot_mode = 1'b0;
    exec_done = 1'b0;
    ibuf_rd_idx = 4'h0;
    failures = 0;
    n_compared = 0;
    cyc = 0;
    a = $urandom(28);
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    // outside bootstrap mode nothing is echoed
    host_u.send_char(8'h35);
    host_u.sent_q.delete();
    check_all();
    boot_mode = 1'b1;
    // slash (just below 0x30) cuts a half address; comment words stay short
    send_hex(32'h1234, 4);
    host_u.send_char(8'h2F);
    b = '{8'h00, 8'hFF};
    send_rec(32'h00004000, b);
    host_u.send_char(8'h20);
    host_u.send_char(8'h6F);
    send_hex(32'h12, 2);
    host_u.send_char(8'h0D);
    check_all();
    // buffer load, padded with no-operation codes
    b = '{8'h30, 8'h3C, 8'h00, 8'h55, 8'h4E, 8'h71, 8'h4E, 8'h71};
    send_rec(IBUF_ADDR, b);
    foreach (b[i]) begin
      ibuf_rd_idx = 4'(i);
      @(negedge sys_clk);
      @(negedge sys_clk);
      cmp(40'(ibuf_rd_q), 40'(b[i]), "buffer byte");
    end
    check_all();
    // run the buffer; a record sent meanwhile is echoed but dropped
    run_exec(IBUF_ADDR, 1'b1);
    send_hex(32'h00005000, 8);
    send_hex(32'h0155, 4);
    host_u.send_char(8'h0D);
    finish_exec();
    check_all();
    run_exec(32'h00004000, 1'b0);
    finish_exec();
    // mid-run reset while a program runs: outputs rest, buffer bytes survive
    run_exec(32'h00004000, 1'b0);
    check_all();
    nrst = 1'b0;
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    cmp(40'({txd_q, exec_req_q, mem_wr_q.valid}), 40'h4, "reset state");
    idx = $urandom_range(7);
    ibuf_rd_idx = 4'(idx);
    @(negedge sys_clk);
    @(negedge sys_clk);
    cmp(40'(ibuf_rd_q), 40'(b[idx]), "buffer kept");
    // leaving bootstrap mode drops a half record and mutes the echo
    send_hex(32'h00004100, 8);
    boot_mode = 1'b0;
    host_u.send_char(8'h35);
    void'(host_u.sent_q.pop_back());
    boot_mode = 1'b1;
    b = '{8'hAA};
    send_rec(32'h00004100, b);
    // random records after execution
    for (int k = 0; k < 6; k++) begin
      a = $urandom() & 32'h7FFFFFFF;
      b.delete();
      repeat (1 + $urandom_range(2)) b.push_back(8'($urandom()));
      send_rec(a, b);
    end
    check_all();
    tally_and_finish();
  end
endmodule // bootstrap_record_loader_bench
